// ==== logic/amit_countdown.sv ====
// down counter used for the standby and peripheral timers
`timescale 1ns/1ps
`include "amit_regs.svh"

module amit_countdown #(
   parameter int CNT_W = 8                   // count width
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             start,        // level: counting allowed
   input  wire logic             auto_restart, // reload after expiry
   input  wire logic             reload,       // pulse: restart countdown
   input  wire logic             tick,         // one-cycle time base
   input  wire logic [CNT_W-1:0] init_count,   // programmed initial count
   output logic      [CNT_W-1:0] count,        // present count
   output logic                  expire        // pulse on reaching zero
);

   amit_pkg::amit_tmr_state_type state_reg;  // run state
   logic                         start_d_reg; // start, one cycle late

   // start edge detect
   always_ff @(posedge clk) begin
      if (rst) begin
         start_d_reg <= 1'b0;
      end else begin
         start_d_reg <= start;
      end
   end

   // run state and count
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= amit_pkg::AMIT_TMR_IDLE;
         count     <= '0;
         expire    <= 1'b0;
      end else begin
         expire <= 1'b0;
         if (!start) begin
            // stopped: hold idle
            state_reg <= amit_pkg::AMIT_TMR_IDLE;
         end else if ((start && !start_d_reg) || reload) begin
            // load initial count and run
            state_reg <= amit_pkg::AMIT_TMR_RUN;
            count     <= init_count;
         end else begin
            case (state_reg)
               amit_pkg::AMIT_TMR_IDLE: begin
                  count <= count;
               end
               amit_pkg::AMIT_TMR_RUN: begin
                  if (tick) begin
                     if (count <= CNT_W'(1)) begin
                        // reaches zero on this tick
                        count  <= '0;
                        expire <= 1'b1;
                        if (auto_restart) begin
                           count <= init_count;
                        end else begin
                           state_reg <= amit_pkg::AMIT_TMR_IDLE;
                        end
                     end else begin
                        count <= count - CNT_W'(1);
                     end
                  end
               end
               default: begin
                  state_reg <= amit_pkg::AMIT_TMR_IDLE;
               end
            endcase
         end
      end
   end

endmodule // amit_countdown

// ==== logic/amit_monitor.sv ====
// activity monitor with standby and peripheral idle timers
// Summary of operation
// - serial port i/o sets activity bit 6
// - parallel port i/o sets activity bit 5
// - video i/o or A/B memory sets bit 4
// - drive command ports or floppy set bit 3
// - bit 1 marks primary interrupt activity
// - enabled primary event reloads standby timer
// - reload records its cause in status
// - standby timeout raises smi when enabled
// - per channel primary, secondary or ignored selection
// - primary interrupts reload standby when enabled
// - secondary interrupts never reload standby timer
// - primary event smi raised when enabled
// - primary event smi also reloads standby
// - selected categories reload the peripheral timer
// - peripheral activity reported in shared status
// - peripheral timer expires only when idle
// - started timers load count, count down
// - timeout sets its own status flag
`timescale 1ns/1ps
`include "amit_regs.svh"

module amit_monitor #(
   parameter int CNT_W       = 8,                  // timer count width
   parameter int IRQ_N       = 16,                 // interrupt channels
   parameter int TICK_CYCLES = `AMIT_TICK_CYCLES   // clocks per timer tick
) (
   input  wire logic                      clk,
   input  wire logic                      rst,
   // host bus decode side
   input  wire amit_pkg::amit_access_type access,
   input  wire logic                      isa_master_active,
   input  wire logic [IRQ_N-1:0]          irq_req,
   // activity registers
   input  wire logic [7:0]                primary_activity_enable,
   input  wire logic [7:0]                peripheral_timer_reload_enable,
   input  wire logic [7:0]                primary_activity_status_clear,
   output logic      [7:0]                primary_activity_status,
   // interrupt classification
   input  wire logic [IRQ_N-1:0]          primary_irq_channel_select,
   input  wire logic [IRQ_N-1:0]          secondary_irq_channel_select,
   // control bits
   input  wire logic                      activity_standby_reload_en,
   input  wire logic                      primary_irq_reload_en,
   input  wire amit_pkg::amit_global_type global_event_enable,
   input  wire amit_pkg::amit_global_type global_event_status_clear,
   output amit_pkg::amit_global_type      global_event_status,
   // timers
   input  wire logic                      standby_timer_start,
   input  wire logic                      peripheral_timer_start,
   input  wire logic                      standby_timer_auto_restart,
   input  wire logic                      peripheral_timer_auto_restart,
   input  wire logic [CNT_W-1:0]          standby_timer_init,
   input  wire logic [CNT_W-1:0]          peripheral_timer_init,
   output logic      [CNT_W-1:0]          standby_timer_count,
   output logic      [CNT_W-1:0]          peripheral_timer_count,
   // smi request toward the processor
   output logic                           smi_req
);

   localparam int DIV_W = $clog2(TICK_CYCLES + 1);  // divider width

   logic [DIV_W-1:0] div_reg;           // time base divider
   logic             tick;              // one-cycle timer tick
   logic [7:0]       access_event;      // decoded activity this cycle
   logic [7:0]       primary_event;     // enabled primary events
   logic [IRQ_N-1:0] irq_d_reg;         // irq lines, one cycle late
   logic [IRQ_N-1:0] irq_rise;          // irq rising edges
   logic             pri_irq_event;     // primary channel fired
   logic             sec_irq_event;     // secondary channel fired
   logic             isa_master_d_reg;  // isa master, one cycle late
   logic             standby_reload;    // restart standby timer
   logic             periph_reload;     // restart peripheral timer
   logic             standby_expire;    // standby timer reached zero
   logic             periph_expire;     // peripheral timer reached zero
   logic             pri_event_smi;     // primary event while smi armed
   logic [15:0]      io;                // i/o address
   logic             io_cyc;            // valid i/o cycle
   logic             mem_cyc;           // valid memory cycle
   logic [7:0]       act_sts_next;      // next activity status
   amit_pkg::amit_global_type gbl_set;  // global status set terms
   amit_pkg::amit_global_type gbl_next; // next global status

   // timer time base divider
   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg <= '0;
      end else if (div_reg >= DIV_W'(TICK_CYCLES - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   assign tick = (div_reg >= DIV_W'(TICK_CYCLES - 1));

   // address decode of one host access
   assign io      = access.addr[15:0];
   assign io_cyc  = access.valid && !access.is_mem;
   assign mem_cyc = access.valid && access.is_mem;

   // activity decode per category
   always_comb begin
      access_event = 8'h_00;
      // keyboard data port
      access_event[`AMIT_BIT_KEYBOARD] = io_cyc && (io == `AMIT_IO_KEYBOARD);
      // four serial port ranges
      access_event[`AMIT_BIT_SERIAL] = io_cyc &&
         ({io[15:3], 3'b000} == `AMIT_IO_COM1 || {io[15:3], 3'b000} == `AMIT_IO_COM2 ||
          {io[15:3], 3'b000} == `AMIT_IO_COM3 || {io[15:3], 3'b000} == `AMIT_IO_COM4);
      // two parallel port ranges
      access_event[`AMIT_BIT_PARALLEL] = io_cyc &&
         ({io[15:3], 3'b000} == `AMIT_IO_LPT1 || {io[15:3], 3'b000} == `AMIT_IO_LPT2);
      // video ports or A/B memory segments
      access_event[`AMIT_BIT_VIDEO] =
         (io_cyc && io >= `AMIT_IO_VIDEO_LO && io <= `AMIT_IO_VIDEO_HI) ||
         (mem_cyc && access.addr[23:20] == 4'h_0 &&
          (access.addr[19:16] == `AMIT_MEM_SEG_A || access.addr[19:16] == `AMIT_MEM_SEG_B));
      // drive command ranges or floppy data port
      access_event[`AMIT_BIT_DISK] = io_cyc &&
         ({io[15:3], 3'b000} == `AMIT_IO_IDE_PRI || {io[15:3], 3'b000} == `AMIT_IO_IDE_SEC ||
          io == `AMIT_IO_FLOPPY_DATA);
      // reserved category never fires
      access_event[`AMIT_BIT_RESERVED] = 1'b0;
      // primary interrupt channel
      access_event[`AMIT_BIT_PRI_IRQ] = pri_irq_event;
      // isa master or dma start
      access_event[`AMIT_BIT_ISA_MASTER] = isa_master_active && !isa_master_d_reg;
   end

   // irq and isa master edge history
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_d_reg        <= '0;
         isa_master_d_reg <= 1'b0;
      end else begin
         irq_d_reg        <= irq_req;
         isa_master_d_reg <= isa_master_active;
      end
   end

   // interrupt classification, primary wins if both selects set
   assign irq_rise      = irq_req & ~irq_d_reg;
   assign pri_irq_event = |(irq_rise & primary_irq_channel_select);
   assign sec_irq_event = |(irq_rise & secondary_irq_channel_select
                            & ~primary_irq_channel_select);

   // enabled primary events, reserved bit masked
   assign primary_event = access_event & primary_activity_enable & `AMIT_ACT_MASK;

   // standby reload: general events, primary irq, or armed smi
   always_comb begin
      standby_reload = 1'b0;
      // non-interrupt categories under the activity reload enable
      if (activity_standby_reload_en &&
          |(primary_event & ~(8'h_01 << `AMIT_BIT_PRI_IRQ))) begin
         standby_reload = 1'b1;
      end
      // primary interrupts under their own reload enable
      if (primary_irq_reload_en && primary_event[`AMIT_BIT_PRI_IRQ]) begin
         standby_reload = 1'b1;
      end
      // armed primary event smi restarts the countdown too
      if (pri_event_smi) begin
         standby_reload = 1'b1;
      end
      // secondary interrupts take no part here
      if (sec_irq_event && !(|primary_event)) begin
         standby_reload = 1'b0;
      end
   end

   assign pri_event_smi = global_event_enable.pri_event && |primary_event;

   // peripheral reload on selected categories only
   assign periph_reload =
      |(access_event & peripheral_timer_reload_enable & `AMIT_PERIPH_MASK);

   // activity status: set on recorded cause, set wins over clear
   always_comb begin
      act_sts_next = primary_activity_status & ~primary_activity_status_clear;
      if (standby_reload) begin
         act_sts_next = act_sts_next | primary_event;
      end
      // peripheral categories share the same status bits
      act_sts_next = act_sts_next |
         (access_event & peripheral_timer_reload_enable & `AMIT_PERIPH_MASK);
      act_sts_next = act_sts_next & `AMIT_ACT_MASK;
   end

   // activity status register
   always_ff @(posedge clk) begin
      if (rst) begin
         primary_activity_status <= `AMIT_ACT_STS_RESET;
      end else begin
         primary_activity_status <= act_sts_next;
      end
   end

   // global status set terms
   always_comb begin
      gbl_set            = '0;
      gbl_set.standby_to = standby_expire;
      gbl_set.periph_to  = periph_expire;
      gbl_set.pri_event  = pri_event_smi;
      gbl_next           = (global_event_status & ~global_event_status_clear) | gbl_set;
   end

   // global status register, set wins over clear
   always_ff @(posedge clk) begin
      if (rst) begin
         global_event_status <= `AMIT_GLOBAL_EVENT_STATUS_RESET;
      end else begin
         global_event_status <= gbl_next;
      end
   end

   // smi held while an enabled status bit stays set
   always_ff @(posedge clk) begin
      if (rst) begin
         smi_req <= 1'b0;
      end else begin
         smi_req <= |(gbl_next & global_event_enable);
      end
   end

   // standby timer
   amit_countdown #(
      .CNT_W        (CNT_W)
   ) u_standby_timer (
      .clk          (clk),
      .rst          (rst),
      .start        (standby_timer_start),
      .auto_restart (standby_timer_auto_restart),
      .reload       (standby_reload),
      .tick         (tick),
      .init_count   (standby_timer_init),
      .count        (standby_timer_count),
      .expire       (standby_expire)
   );

   // peripheral timer, reloaded by any selected access so it expires only when idle
   amit_countdown #(
      .CNT_W        (CNT_W)
   ) u_peripheral_timer (
      .clk          (clk),
      .rst          (rst),
      .start        (peripheral_timer_start),
      .auto_restart (peripheral_timer_auto_restart),
      .reload       (periph_reload),
      .tick         (tick),
      .init_count   (peripheral_timer_init),
      .count        (peripheral_timer_count),
      .expire       (periph_expire)
   );

endmodule // amit_monitor

// ==== logic/amit_pkg.sv ====
// type package for the activity monitor idle timers
package amit_pkg;

   // one host bus access as seen by the decode logic
   typedef struct packed {
      logic        valid;   // one-cycle strobe per access
      logic        is_mem;  // memory cycle, else i/o cycle
      logic [23:0] addr;    // byte address
   } amit_access_type;

   // global enables and status in one bundle
   typedef struct packed {
      logic pri_event;      // primary event smi
      logic periph_to;      // peripheral timer timeout
      logic standby_to;     // standby timer timeout
   } amit_global_type;

   // timer run state
   typedef enum logic [0:0] {
      AMIT_TMR_IDLE = 1'b0,
      AMIT_TMR_RUN  = 1'b1
   } amit_tmr_state_type;

endpackage

// ==== logic/amit_regs.svh ====
// constant header for the activity monitor idle timers
`ifndef AMIT_REGS_SVH
`define AMIT_REGS_SVH

// activity bit positions, shared by status, enable and reload enable
`define AMIT_BIT_KEYBOARD    3'd7
`define AMIT_BIT_SERIAL      3'd6
`define AMIT_BIT_PARALLEL    3'd5
`define AMIT_BIT_VIDEO       3'd4
`define AMIT_BIT_DISK        3'd3
`define AMIT_BIT_RESERVED    3'd2
`define AMIT_BIT_PRI_IRQ     3'd1
`define AMIT_BIT_ISA_MASTER  3'd0

// writable bits of the activity registers, reserved bit 2 held at zero
`define AMIT_ACT_MASK        8'h_FB
// categories that may reload the peripheral timer
`define AMIT_PERIPH_MASK     8'h_D8

// reset values
`define AMIT_ACT_STS_RESET   8'h_00
`define AMIT_GLOBAL_EVENT_STATUS_RESET   3'h_0

// global status bit positions
`define AMIT_GBL_STANDBY_TO  2'd0
`define AMIT_GBL_PERIPH_TO   2'd1
`define AMIT_GBL_PRI_EVENT   2'd2

// legacy address decode
`define AMIT_IO_KEYBOARD     16'h_0060
`define AMIT_IO_COM1         16'h_03F8
`define AMIT_IO_COM2         16'h_02F8
`define AMIT_IO_COM3         16'h_03E8
`define AMIT_IO_COM4         16'h_02E8
`define AMIT_IO_LPT1         16'h_0378
`define AMIT_IO_LPT2         16'h_0278
`define AMIT_IO_VIDEO_LO     16'h_03B0
`define AMIT_IO_VIDEO_HI     16'h_03DF
`define AMIT_IO_IDE_PRI      16'h_01F0
`define AMIT_IO_IDE_SEC      16'h_0170
`define AMIT_IO_FLOPPY_DATA  16'h_03F5
// memory A and B segments: a0000h to bffffh
`define AMIT_MEM_SEG_A       4'h_A
`define AMIT_MEM_SEG_B       4'h_B

// timing: timer tick period in ns and clock period in ns
`define AMIT_TICK_PERIOD_NS  1000000
`define AMIT_CLK_PERIOD_NS   40
`define AMIT_TICK_CYCLES     (`AMIT_TICK_PERIOD_NS / `AMIT_CLK_PERIOD_NS)

`endif

// ==== verification/amit_host_model.sv ====
// host bus decode and interrupt line model feeding the monitor
`timescale 1ns/1ps
module amit_host_model #(
   parameter int IRQ_N = 16   // interrupt channels
) (
   input  wire logic                 clk,
   output amit_pkg::amit_access_type access,
   output logic                      isa_master_active,
   output logic [IRQ_N-1:0]          irq_req
);
   // idle bus, no requests pending
   initial begin
      access = '0;
      access.addr = 24'hFF_FFFF;
      isa_master_active = 1'b0;
      irq_req = '0;
   end
   // one decoded access, strobe held for one cycle
   task automatic bus_cycle(input logic m, input logic [23:0] a);
      @(posedge clk);
      #1;
      access.valid = 1'b1;
      access.is_mem = m;
      access.addr = a;
      @(posedge clk);
      #1;
      access.valid = 1'b0;
      access.addr = ~a;   // released bus shows no stale address
   endtask
   // one rising edge on an interrupt channel
   task automatic irq_pulse(input int ch);
      @(posedge clk);
      #1;
      irq_req[ch] = 1'b1;
      @(posedge clk);
      #1;
      irq_req[ch] = 1'b0;
   endtask
   // short bus master burst
   task automatic isa_burst;
      @(posedge clk);
      #1;
      isa_master_active = 1'b1;
      @(posedge clk);
      #1;
      isa_master_active = 1'b0;
   endtask
endmodule // amit_host_model

// ==== verification/amit_monitor_properties.sv ====
// assertion checker for the activity monitor idle timers
`timescale 1ns/1ps
module amit_monitor_properties #(
   parameter int CNT_W = 8   // timer count width
) (
   input wire logic                      clk,
   input wire logic                      rst,
   input wire amit_pkg::amit_access_type access,
   input wire logic [7:0]                primary_activity_enable,
   input wire logic [7:0]                peripheral_timer_reload_enable,
   input wire logic [7:0]                primary_activity_status_clear,
   input wire logic [7:0]                primary_activity_status,
   input wire logic                      activity_standby_reload_en,
   input wire amit_pkg::amit_global_type global_event_enable,
   input wire amit_pkg::amit_global_type global_event_status_clear,
   input wire amit_pkg::amit_global_type global_event_status,
   input wire logic                      standby_timer_start,
   input wire logic                      peripheral_timer_start,
   input wire logic                      standby_timer_auto_restart,
   input wire logic [CNT_W-1:0]          standby_timer_init,
   input wire logic [CNT_W-1:0]          peripheral_timer_init,
   input wire logic [CNT_W-1:0]          standby_timer_count,
   input wire logic [CNT_W-1:0]          peripheral_timer_count,
   input wire logic                      smi_req
);
   // one clock domain, reset masks everything
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic io_hit;   // i/o access strobe
   logic rld_ok;   // standby reload path open
   assign io_hit = access.valid && !access.is_mem;
   assign rld_ok = activity_standby_reload_en && standby_timer_start;

   a_reserved_bit_low: assert property (primary_activity_status[2] == 1'b0)
      else $error("reserved activity bit set");
   a_serial_reload: assert property (io_hit && access.addr == 24'h00_03F8 && primary_activity_enable[6] && rld_ok
      |=> primary_activity_status[6] && standby_timer_count == $past(standby_timer_init))
      else $error("serial access did not reload standby timer");
   a_video_mem_flag: assert property (access.valid && access.is_mem && access.addr[23:16] == 8'h0A
      && primary_activity_enable[4] && rld_ok |=> primary_activity_status[4])
      else $error("segment A access not flagged");
   a_periph_reload: assert property (io_hit && access.addr == 24'h00_0060 && peripheral_timer_reload_enable[7]
      && peripheral_timer_start |=> primary_activity_status[7] && peripheral_timer_count == $past(peripheral_timer_init))
      else $error("keyboard access did not reload peripheral timer");
   a_status_sticky: assert property (((($past(primary_activity_status) & ~$past(primary_activity_status_clear))
      & ~primary_activity_status) == 8'h00))
      else $error("activity status lost without clear");
   a_timeout_sticky: assert property ($past(global_event_status.standby_to)
      && !$past(global_event_status_clear.standby_to) |-> global_event_status.standby_to)
      else $error("standby timeout flag lost without clear");
   a_smi_tracks_status: assert property (smi_req == |(global_event_status & $past(global_event_enable)))
      else $error("smi request disagrees with enabled status");
   a_timeout_at_zero: assert property ($rose(global_event_status.standby_to) && !standby_timer_auto_restart
      |-> standby_timer_count == 8'h00)
      else $error("standby timeout with nonzero count");
endmodule // amit_monitor_properties

bind amit_monitor amit_monitor_properties #(.CNT_W(CNT_W)) u_props (.clk(clk), .rst(rst), .access(access),
   .primary_activity_enable(primary_activity_enable), .peripheral_timer_reload_enable(peripheral_timer_reload_enable),
   .primary_activity_status_clear(primary_activity_status_clear), .primary_activity_status(primary_activity_status),
   .activity_standby_reload_en(activity_standby_reload_en), .global_event_enable(global_event_enable),
   .global_event_status_clear(global_event_status_clear), .global_event_status(global_event_status),
   .standby_timer_start(standby_timer_start), .peripheral_timer_start(peripheral_timer_start),
   .standby_timer_auto_restart(standby_timer_auto_restart), .standby_timer_init(standby_timer_init),
   .peripheral_timer_init(peripheral_timer_init), .standby_timer_count(standby_timer_count),
   .peripheral_timer_count(peripheral_timer_count), .smi_req(smi_req));

// ==== verification/tb_activity_monitor_idle_timers.sv ====
// self-checking bench for the activity monitor idle timers
`timescale 1ns/1ps
module tb_activity_monitor_idle_timers;
   typedef struct packed {logic m; logic [23:0] a; logic [7:0] e;} amit_row_type;
   logic clk, rst, sar, std_start, per_start, smi_req;
   logic activity_standby_reload_en, primary_irq_reload_en;
   logic [7:0] act_en, prte, clr, status, std_init, per_init, std_cnt, per_cnt;
   logic [15:0] pri_sel, sec_sel, irq_req;
   logic isa;
   amit_pkg::amit_access_type access;
   amit_pkg::amit_global_type ge, gclr, gs;
   int n_errors = 0, comparisons = 0, i;
   // table rows: access kind, address, status bits expected
   amit_row_type rows [0:22] = '{
      '{1'b0, 24'h00_03F8, 8'h40}, '{1'b0, 24'h00_03FF, 8'h40}, '{1'b0, 24'h00_02F8, 8'h40}, '{1'b0, 24'h00_02FF, 8'h40},
      '{1'b0, 24'h00_03E8, 8'h40}, '{1'b0, 24'h00_03EF, 8'h40}, '{1'b0, 24'h00_02E8, 8'h40}, '{1'b0, 24'h00_02EF, 8'h40},
      '{1'b0, 24'h00_0378, 8'h20}, '{1'b0, 24'h00_027F, 8'h20}, '{1'b0, 24'h00_03B0, 8'h10}, '{1'b0, 24'h00_03DF, 8'h10},
      '{1'b1, 24'h0A_0000, 8'h10}, '{1'b1, 24'h0B_FFFF, 8'h10}, '{1'b0, 24'h00_01F0, 8'h08}, '{1'b0, 24'h00_0177, 8'h08},
      '{1'b0, 24'h00_03F5, 8'h08}, '{1'b0, 24'h00_0060, 8'h80}, '{1'b0, 24'h00_03F4, 8'h00}, '{1'b0, 24'h00_03E0, 8'h00},
      '{1'b1, 24'h0C_0000, 8'h00}, '{1'b1, 24'h00_03F8, 8'h00}, '{1'b0, 24'h00_0170, 8'h08}};

   // clock source, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   amit_host_model u_host (.clk(clk), .access(access), .isa_master_active(isa), .irq_req(irq_req));
   amit_monitor #(.TICK_CYCLES(4)) DUT (.clk(clk), .rst(rst), .access(access), .isa_master_active(isa),
      .irq_req(irq_req), .primary_activity_enable(act_en), .peripheral_timer_reload_enable(prte),
      .primary_activity_status_clear(clr), .primary_activity_status(status), .primary_irq_channel_select(pri_sel),
      .secondary_irq_channel_select(sec_sel), .activity_standby_reload_en(activity_standby_reload_en),
      .primary_irq_reload_en(primary_irq_reload_en), .global_event_enable(ge), .global_event_status_clear(gclr),
      .global_event_status(gs), .standby_timer_start(std_start), .peripheral_timer_start(per_start),
      .standby_timer_auto_restart(sar), .peripheral_timer_auto_restart(sar), .standby_timer_init(std_init),
      .peripheral_timer_init(per_init), .standby_timer_count(std_cnt), .peripheral_timer_count(per_cnt),
      .smi_req(smi_req));

   // compare one value and count it
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // wait n edges, land just after the last
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // write-1-to-clear every status bit
   task automatic clear_all;
      clr = 8'hFF;
      gclr = 3'h7;
      step(1);
      clr = 8'h00;
      gclr = 3'h0;
   endtask
   // restart the standby timer from a fresh count
   task automatic restart_standby(input logic [7:0] n);
      std_start = 1'b0;
      std_init = n;
      step(1);
      std_start = 1'b1;
      step(1);
   endtask
   // print counts, verdict and stop
   task automatic results;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #(40 * 6000);
      n_errors++;
      results();
   end

   // main sequence
   initial begin
      {sar, std_start, per_start, primary_irq_reload_en, activity_standby_reload_en} = '0;
      {act_en, prte, clr, std_init, per_init, pri_sel, sec_sel} = '0;
      {ge, gclr} = '0;
      rst = 1'b1;
      step(4);
      rst = 1'b0;
      check("reset status", status, 8'h00);
      check("reset counts", {std_cnt, per_cnt, 5'h00, gs, 7'h00, smi_req}, 32'h0);
      act_en = 8'hFF;
      activity_standby_reload_en = 1'b1;
      restart_standby(8'hF0);
      foreach (rows[k]) begin
         u_host.bus_cycle(rows[k].m, rows[k].a);
         check("activity status", status, rows[k].e);
         if (rows[k].e != 8'h00) check("standby reload", std_cnt, 8'hF0);
         clear_all();
      end
      $display("test decode done");
      // channel 7 is in both selects and counts as primary
      pri_sel = 16'h0088;
      sec_sel = 16'h00A0;
      primary_irq_reload_en = 1'b1;
      // a reload would show this marker count
      std_init = 8'h55;
      u_host.irq_pulse(5);
      check("secondary irq", {status, 7'h00, std_cnt == 8'h55}, 16'h0000);
      u_host.irq_pulse(3);
      check("primary irq", {status, std_cnt}, {8'h02, 8'h55});
      clear_all();
      u_host.irq_pulse(7);
      check("dual select irq", status, 8'h02);
      clear_all();
      u_host.irq_pulse(12);
      check("ignored irq", status, 8'h00);
      u_host.isa_burst();
      check("bus master", status, 8'h01);
      clear_all();
      $display("test interrupts done");
      // standby timeout while only secondary interrupts arrive
      restart_standby(8'h03);
      for (i = 0; i < 60 && gs.standby_to !== 1'b1; i++) u_host.irq_pulse(5);
      check("standby timeout", {gs.standby_to, smi_req, std_cnt}, {2'b10, 8'h00});
      ge = 3'h1;
      step(1);
      check("smi on timeout", smi_req, 1'b1);
      gclr = 3'h1;
      step(1);
      gclr = 3'h0;
      check("smi after clear", {smi_req, gs.standby_to}, 2'b00);
      $display("test standby done");
      // primary event smi restarts the countdown
      ge = 3'h4;
      restart_standby(8'hF0);
      step(8);
      u_host.bus_cycle(1'b0, 24'h00_03F8);
      check("event smi", {smi_req, gs.pri_event, std_cnt}, {2'b11, 8'hF0});
      clear_all();
      check("event smi clear", smi_req, 1'b0);
      $display("test event smi done");
      // peripheral timer kept alive by keyboard only
      activity_standby_reload_en = 1'b0;
      ge = 3'h2;
      prte = 8'h80;
      per_init = 8'h06;
      per_start = 1'b1;
      for (i = 0; i < 10; i++) begin
         u_host.bus_cycle(1'b0, 24'h00_0060);
         step(6);
         check("periph busy", gs.periph_to, 1'b0);
      end
      for (i = 0; i < 60 && gs.periph_to !== 1'b1; i++) u_host.bus_cycle(1'b0, 24'h00_03F8);
      check("periph idle", {gs.periph_to, smi_req, per_cnt}, {2'b11, 8'h00});
      // auto restart reloads the initial count at expiry
      per_start = 1'b0;
      step(1);
      sar = 1'b1;
      per_start = 1'b1;
      clear_all();
      for (i = 0; i < 60 && gs.periph_to !== 1'b1; i++) step(1);
      check("periph restart", {gs.periph_to, per_cnt}, {1'b1, 8'h06});
      $display("test peripheral done");
      results();
   end
endmodule // tb_activity_monitor_idle_timers
